// file: design/wwd_pkg.sv
//
// Behaviour
// - New target voltage ramps at selected slew
// - Forced switching while ramping, else configured mode
// - Pin sequencing when enabled and selector nonzero
// - Pin edges apply on/off delays
// - Register enable acts without delays
// - Every expiry pulses configurable reset output
// - Lock bit blocks watchdog control writes
// - Long-open or open window timeout expires
// - Kick during close window expires
// - Control write restarts long-open, not stopped
// - Selector 00: 10ms pulse, no restart
// - Selector 01: shutdown then start-up, optional reload
// - Restart pulse is 10ms plus max shutdown
// - Restart flag set, cleared by write one
// - Selectors 10/11 restart after 2/4 expiries
// - Flag and counter clearable while locked
// - Pin configured but inactive: 31ms, no shutdown
// - Register-only enables: 11ms, no converter action
// - Long-open and close window period tables
// - Software reset: outputs off, defaults, bus kept
// - After reset release, load defaults, start watchdog
package wwd_pkg;
  localparam int CLOCK_NS      = 20;
  localparam int TICK_US       = 500;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLOCK_NS;
  localparam int KICK_MIN_US   = 100;
  localparam int KICK_CYCLES   = (KICK_MIN_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int BOOT_US       = 1200;
  localparam int BOOT_CYCLES   = (BOOT_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int PULSE_US      = 10000;
  localparam int PINLOW_US     = 31000;
  localparam int REGONLY_US    = 11000;
  localparam int SHUT_SHORT_US = 7500;
  localparam int SHUT_LONG_US  = 15000;
  localparam logic [13:0] PULSE_T    = 14'(PULSE_US / TICK_US);
  localparam logic [13:0] PINLOW_T   = 14'(PINLOW_US / TICK_US);
  localparam logic [13:0] REGONLY_T  = 14'(REGONLY_US / TICK_US);
  localparam logic [13:0] SHUT_S_T   = 14'(SHUT_SHORT_US / TICK_US);
  localparam logic [13:0] SHUT_L_T   = 14'(SHUT_LONG_US / TICK_US);
  localparam logic [10:0] RAMP_BASE  = 11'h008;
  localparam int ADDR_W = 6;
  localparam logic [5:0] WD_CTRL1_ADDR = 6'h20;
  localparam logic [5:0] WD_CTRL2_ADDR = 6'h24;
  localparam logic [5:0] WD_STAT_ADDR  = 6'h28;
  localparam logic [5:0] RESET_ADDR    = 6'h2c;
  localparam logic [5:0] DEV_STAT_ADDR = 6'h30;
  localparam logic [1:0] BK_CTRL1 = 2'h0;
  localparam logic [1:0] BK_CTRL2 = 2'h1;
  localparam logic [1:0] BK_VOUT  = 2'h2;
  localparam logic [1:0] BK_DELAY = 2'h3;
  localparam int WD1_EN = 0;
  localparam int WD1_LO = 1;
  localparam int WD1_CL = 3;
  localparam int WD1_OP = 5;
  localparam int WD2_LOCK = 0;
  localparam int WD2_SEL = 1;
  localparam int WD2_RELOAD = 3;
  localparam int WD2_RANGE = 4;
  localparam int WD2_POL = 5;
  localparam int WD2_OD = 6;
  localparam int CLR_FLAG = 0;
  localparam int CLR_CNT = 1;
  localparam int RST_SW = 0;
  localparam int RST_GPO = 1;
  localparam logic [7:0] WD1_DEFAULT   = 8'h01;
  localparam logic [7:0] WD2_DEFAULT   = 8'h02;
  localparam logic [7:0] CTRL1_DEFAULT = 8'h00;
  localparam logic [7:0] CTRL2_DEFAULT = 8'h00;
  localparam logic [7:0] VOUT_DEFAULT  = 8'h32;
  localparam logic [7:0] DELAY_DEFAULT = 8'h00;
  typedef enum logic [1:0] {wd_long_open, wd_close, wd_open, wd_pulse} wd_state_t;
  typedef enum logic [1:0] {pend_none, pend_on, pend_off} pend_t;
  function automatic logic [13:0] long_open_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    long_open_ticks = 14'(200 * 1000 / TICK_US);
      2'h1:    long_open_ticks = 14'(600 * 1000 / TICK_US);
      2'h2:    long_open_ticks = 14'(2000 * 1000 / TICK_US);
      default: long_open_ticks = 14'(5000 * 1000 / TICK_US);
    endcase
  endfunction
  function automatic logic [13:0] window_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    window_ticks = 14'(10 * 1000 / TICK_US);
      2'h1:    window_ticks = 14'(20 * 1000 / TICK_US);
      2'h2:    window_ticks = 14'(50 * 1000 / TICK_US);
      default: window_ticks = 14'(100 * 1000 / TICK_US);
    endcase
  endfunction
endpackage

// file: design/conv_if.sv
`timescale 1ns/100ps
interface conv_if;
  logic       enable_bit;
  logic [1:0] pin_select;
  logic [3:0] on_delay;
  logic [3:0] off_delay;
  logic [7:0] target;
  logic [2:0] slew;
  logic       fpwm;
  logic       long_range;
  logic       hold_off;
  logic       force_off;
  logic       tick;
  logic [2:0] pins;
  logic       conv_on;
  logic       ramping;
  logic       forced_switching;
  logic [7:0] voltage_now;
  modport ctrl (output enable_bit, pin_select, on_delay, off_delay, target, slew, fpwm, long_range,
                hold_off, force_off, tick, pins, input conv_on, ramping, forced_switching, voltage_now);
  modport chan (input enable_bit, pin_select, on_delay, off_delay, target, slew, fpwm, long_range,
                hold_off, force_off, tick, pins, output conv_on, ramping, forced_switching, voltage_now);
endinterface

// file: design/buck_channel.sv
`timescale 1ns/100ps
module buck_channel (
  input  wire logic clock,
  input  wire logic resetn,
  conv_if.chan      c
);
  import wwd_pkg::*;
  logic       pin_ctrl;
  logic       sel_pin;
  logic       prev_pin;
  logic [4:0] on_t;
  logic [4:0] off_t;
  logic [4:0] count;
  pend_t      pend;
  logic [9:0] div;
  assign pin_ctrl = c.enable_bit && c.pin_select != 2'h0;
  // A restart holds the pin low, so shutdown then start-up replay the pin delays
  assign sel_pin  = pin_ctrl && c.pins[c.pin_select - 2'h1] && !c.hold_off;
  assign on_t     = c.long_range ? {c.on_delay, 1'b0} : {1'b0, c.on_delay};
  assign off_t    = c.long_range ? {c.off_delay, 1'b0} : {1'b0, c.off_delay};
  assign c.ramping = c.conv_on && c.voltage_now != c.target;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c.conv_on <= 1'b0;
      prev_pin  <= 1'b0;
      count     <= 5'h00;
      pend      <= pend_none;
    end else if (c.force_off) begin
      c.conv_on <= 1'b0;
      prev_pin  <= 1'b0;
      pend      <= pend_none;
    end else if (!pin_ctrl) begin
      c.conv_on <= c.enable_bit;
      prev_pin  <= c.enable_bit;
      pend      <= pend_none;
    end else begin
      prev_pin <= sel_pin;
      if (sel_pin && !prev_pin) begin
        if (on_t == 5'h00) c.conv_on <= 1'b1;
        else begin
          count <= on_t;
          pend  <= pend_on;
        end
      end else if (!sel_pin && prev_pin) begin
        if (off_t == 5'h00) c.conv_on <= 1'b0;
        else begin
          count <= off_t;
          pend  <= pend_off;
        end
      end else if (pend != pend_none && c.tick) begin
        count <= count - 5'h01;
        if (count == 5'h01) begin
          c.conv_on <= pend == pend_on;
          pend      <= pend_none;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c.voltage_now      <= VOUT_DEFAULT;
      c.forced_switching <= 1'b0;
      div                <= 10'h000;
    end else begin
      c.forced_switching <= c.ramping || c.fpwm;
      if (!c.conv_on) begin
        c.voltage_now <= c.target;
        div           <= 10'h000;
      end else if (c.ramping) begin
        if (div == 10'h000) begin
          div           <= 10'((RAMP_BASE << c.slew) - 11'h001);
          c.voltage_now <= c.voltage_now < c.target ? c.voltage_now + 8'h01 : c.voltage_now - 8'h01;
        end else div <= div - 10'h001;
      end
    end
  end
endmodule // buck_channel

// file: design/window_watchdog_sequencer.sv
`timescale 1ns/100ps
module window_watchdog_sequencer #(
  parameter int BUCK_COUNT  = 2,
  parameter int TICK_CYCLES = wwd_pkg::TICK_CYCLES,
  parameter int KICK_CYCLES = wwd_pkg::KICK_CYCLES,
  parameter int BOOT_CYCLES = wwd_pkg::BOOT_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [wwd_pkg::ADDR_W-1:0]  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  input  wire logic                        main_supply_input_ok,
  input  wire logic                        enable_input_one,
  input  wire logic                        enable_input_two,
  input  wire logic                        enable_input_three,
  input  wire logic                        watchdog_kick_input,
  input  wire logic                        watchdog_reset_output_in,
  output logic                             watchdog_reset_output,
  output logic                             watchdog_reset_output_oe,
  output logic      [BUCK_COUNT-1:0]       buck_enable,
  output logic      [BUCK_COUNT-1:0][7:0]  buck_voltage_code,
  output logic      [BUCK_COUNT-1:0]       buck_forced_switching,
  output logic      [1:0]                  general_outputs
);
  import wwd_pkg::*;

  // Channel address decode uses a single address bit
  if (BUCK_COUNT < 1 || BUCK_COUNT > 2) begin : g_bad_count
    $error("BUCK_COUNT must be 1 or 2");
  end
  if (TICK_CYCLES < 2 || KICK_CYCLES < 2 || BOOT_CYCLES < 2) begin : g_bad_time
    $error("timing parameters must be at least 2");
  end

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int KW = $clog2(KICK_CYCLES + 1);
  localparam int BW = $clog2(BOOT_CYCLES + 1);

  function automatic logic is_buck(input logic [ADDR_W-1:0] a);
    is_buck = !a[5] && 32'(a[4]) < BUCK_COUNT;
  endfunction

  logic [7:0]      ctrl1 [BUCK_COUNT];
  logic [7:0]      ctrl2 [BUCK_COUNT];
  logic [7:0]      vout  [BUCK_COUNT];
  logic [7:0]      dly   [BUCK_COUNT];
  logic [7:0]      wd1;
  logic [7:0]      wd2;
  logic            req;
  logic            ack;
  logic            next_ack;
  logic            wr_go;
  logic [31:0]     rd_mux;
  logic [BW-1:0]   boot_cnt;
  logic            booting;
  logic            software_reset_bit_req;
  logic            soft_rst;
  logic            reload;
  logic [TW-1:0]   tick_div;
  logic            tick;
  logic [KW-1:0]   kick_run;
  logic            kick_pulse;
  wd_state_t       wd_state;
  logic [13:0]     wd_ticks;
  logic [13:0]     lim;
  logic            timeout;
  logic [13:0]     pulse_len;
  logic            restart_run;
  logic            due_run;
  logic [2:0]      exp_count;
  logic [2:0]      next_count;
  logic            restart_flag;
  logic            expire;
  logic            due;
  logic [13:0]     next_pulse;
  logic            next_restart;
  logic            wd_wr;
  logic            pulse_end;
  logic            rst_level;
  logic [BUCK_COUNT-1:0] pin_cfg;
  logic [BUCK_COUNT-1:0] pin_act;
  logic [BUCK_COUNT-1:0] ramp_st;

  // Bus slave: one wait state per access, longer while the device boots
  assign req         = read || write;
  assign waitrequest = req && !ack;
  assign next_ack    = req && !ack && !booting;
  assign wr_go       = write && ack;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      if (next_ack && read) readdata <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_buck(address)) begin
      case (address[3:2])
        BK_CTRL1: rd_mux[7:0] = ctrl1[address[4]];
        BK_CTRL2: rd_mux[7:0] = ctrl2[address[4]];
        BK_VOUT:  rd_mux[7:0] = vout[address[4]];
        default:  rd_mux[7:0] = dly[address[4]];
      endcase
    end else begin
      case (address)
        WD_CTRL1_ADDR: rd_mux[7:0] = wd1;
        WD_CTRL2_ADDR: rd_mux[7:0] = wd2;
        WD_STAT_ADDR:  rd_mux[3:0] = {exp_count, restart_flag};
        RESET_ADDR:    rd_mux[2:0] = {general_outputs, 1'b0};
        DEV_STAT_ADDR: rd_mux[15:0] = {6'h00, wd_state, 4'(ramp_st), 4'(buck_enable)};
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Supply loss acts like the reset pin but keeps the bus slave alive
  assign software_reset_bit_req = wr_go && address == RESET_ADDR && writedata[RST_SW];
  assign soft_rst     = software_reset_bit_req || !main_supply_input_ok;
  assign reload       = soft_rst || (pulse_end && restart_run && wd2[WD2_RELOAD]);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) boot_cnt <= BW'(BOOT_CYCLES);
    else if (soft_rst) boot_cnt <= BW'(BOOT_CYCLES);
    else if (booting) boot_cnt <= boot_cnt - BW'(1);
  end
  assign booting = boot_cnt != '0;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BUCK_COUNT; i++) begin
        ctrl1[i] <= CTRL1_DEFAULT;
        ctrl2[i] <= CTRL2_DEFAULT;
        vout[i]  <= VOUT_DEFAULT;
        dly[i]   <= DELAY_DEFAULT;
      end
    end else if (reload) begin
      for (int i = 0; i < BUCK_COUNT; i++) begin
        ctrl1[i] <= CTRL1_DEFAULT;
        ctrl2[i] <= CTRL2_DEFAULT;
        vout[i]  <= VOUT_DEFAULT;
        dly[i]   <= DELAY_DEFAULT;
      end
    end else if (wr_go && is_buck(address)) begin
      case (address[3:2])
        BK_CTRL1: ctrl1[address[4]] <= writedata[7:0];
        BK_CTRL2: ctrl2[address[4]] <= writedata[7:0];
        BK_VOUT:  vout[address[4]]  <= writedata[7:0];
        default:  dly[address[4]]   <= writedata[7:0];
      endcase
    end
  end

  // Lock survives a watchdog reload; only reset pin, supply or software reset free it
  assign wd_wr = wr_go && (address == WD_CTRL1_ADDR || address == WD_CTRL2_ADDR);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wd1 <= WD1_DEFAULT;
      wd2 <= WD2_DEFAULT;
    end else if (soft_rst) begin
      wd1 <= WD1_DEFAULT;
      wd2 <= WD2_DEFAULT;
    end else if (reload) begin
      wd1 <= WD1_DEFAULT;
      wd2 <= WD2_DEFAULT | (wd2 & (8'h01 << WD2_LOCK));
    end else if (wd_wr && !wd2[WD2_LOCK]) begin
      if (address == WD_CTRL1_ADDR) wd1 <= writedata[7:0];
      else wd2 <= writedata[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) general_outputs <= 2'h0;
    else if (soft_rst) general_outputs <= 2'h0;
    else if (wr_go && address == RESET_ADDR) general_outputs <= writedata[RST_GPO+:2];
  end

  // Half-millisecond time base for every window, pulse and delay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) tick_div <= '0;
    else if (tick) tick_div <= '0;
    else tick_div <= tick_div + TW'(1);
  end
  assign tick = tick_div == TW'(TICK_CYCLES - 1);

  // A kick counts once, when it has been high for the least width
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) kick_run <= '0;
    else if (!watchdog_kick_input) kick_run <= '0;
    else if (kick_run != KW'(KICK_CYCLES)) kick_run <= kick_run + KW'(1);
  end
  assign kick_pulse = watchdog_kick_input && kick_run == KW'(KICK_CYCLES - 1);

  for (genvar g = 0; g < BUCK_COUNT; g++) begin : g_pin
    logic [2:0] pins;
    assign pins       = {enable_input_three, enable_input_two, enable_input_one};
    assign pin_cfg[g] = ctrl1[g][0] && ctrl1[g][2:1] != 2'h0;
    assign pin_act[g] = pin_cfg[g] && pins[ctrl1[g][2:1] - 2'h1];
  end

  always_comb begin
    case (wd_state)
      wd_long_open: lim = long_open_ticks(wd1[WD1_LO+:2]);
      wd_close:     lim = window_ticks(wd1[WD1_CL+:2]);
      wd_open:      lim = window_ticks(wd1[WD1_OP+:2]);
      default:      lim = pulse_len;
    endcase
  end
  assign timeout   = tick && wd_ticks == lim - 14'h0001;
  assign pulse_end = wd_state == wd_pulse && timeout;

  always_comb begin
    expire = 1'b0;
    case (wd_state)
      wd_long_open: expire = !kick_pulse && timeout;
      wd_close:     expire = kick_pulse;
      wd_open:      expire = !kick_pulse && timeout;
      default:      expire = 1'b0;
    endcase
    if (!wd1[WD1_EN] || booting) expire = 1'b0;
  end

  // Expiry outcome: pulse length and whether converters cycle
  always_comb begin
    next_count   = exp_count == 3'h7 ? exp_count : exp_count + 3'h1;
    next_pulse   = PULSE_T;
    next_restart = 1'b0;
    case (wd2[WD2_SEL+:2])
      2'h1:    due = 1'b1;
      2'h2:    due = next_count >= 3'h2;
      2'h3:    due = next_count >= 3'h4;
      default: due = 1'b0;
    endcase
    if (due) begin
      if (|pin_act) begin
        next_pulse   = PULSE_T + (wd2[WD2_RANGE] ? SHUT_L_T : SHUT_S_T);
        next_restart = 1'b1;
      end else if (|pin_cfg) next_pulse = PINLOW_T;
      else next_pulse = REGONLY_T;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wd_state    <= wd_long_open;
      wd_ticks    <= 14'h0000;
      pulse_len   <= PULSE_T;
      restart_run <= 1'b0;
      due_run     <= 1'b0;
    end else if (soft_rst || booting || !wd1[WD1_EN]) begin
      wd_state    <= wd_long_open;
      wd_ticks    <= 14'h0000;
      restart_run <= 1'b0;
      due_run     <= 1'b0;
    end else if (expire) begin
      wd_state    <= wd_pulse;
      wd_ticks    <= 14'h0000;
      pulse_len   <= next_pulse;
      restart_run <= next_restart;
      due_run     <= due;
    end else if (wd_state == wd_pulse) begin
      if (timeout) begin
        wd_state    <= wd_long_open;
        wd_ticks    <= 14'h0000;
        restart_run <= 1'b0;
        due_run     <= 1'b0;
      end else if (tick) wd_ticks <= wd_ticks + 14'h0001;
    end else if (wd_wr) begin
      wd_state <= wd_long_open;
      wd_ticks <= 14'h0000;
    end else if (kick_pulse) begin
      wd_state <= wd_close;
      wd_ticks <= 14'h0000;
    end else if (timeout) begin
      wd_state <= wd_open;
      wd_ticks <= 14'h0000;
    end else if (tick) wd_ticks <= wd_ticks + 14'h0001;
  end

  // Hardware events win over a software clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) exp_count <= 3'h0;
    else if (soft_rst) exp_count <= 3'h0;
    else if (expire) exp_count <= next_count;
    else if (pulse_end && due_run) exp_count <= 3'h0;
    else if (wr_go && address == WD_STAT_ADDR && writedata[CLR_CNT]) exp_count <= 3'h0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) restart_flag <= 1'b0;
    else if (soft_rst) restart_flag <= 1'b0;
    else if (pulse_end && restart_run) restart_flag <= 1'b1;
    else if (wr_go && address == WD_STAT_ADDR && writedata[CLR_FLAG]) restart_flag <= 1'b0;
  end

  // Open drain only ever pulls low, whatever the chosen polarity
  assign rst_level = wd2[WD2_POL] ? wd_state == wd_pulse : wd_state != wd_pulse;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      watchdog_reset_output    <= 1'b0;
      watchdog_reset_output_oe <= 1'b1;
    end else begin
      watchdog_reset_output    <= rst_level;
      watchdog_reset_output_oe <= !wd2[WD2_OD] || !rst_level;
    end
  end

  for (genvar g = 0; g < BUCK_COUNT; g++) begin : g_buck
    conv_if cif ();
    assign cif.enable_bit = ctrl1[g][0];
    assign cif.pin_select = ctrl1[g][2:1];
    assign cif.on_delay   = dly[g][3:0];
    assign cif.off_delay  = dly[g][7:4];
    assign cif.target     = vout[g];
    assign cif.slew       = ctrl2[g][2:0];
    assign cif.fpwm       = ctrl2[g][3];
    assign cif.long_range = wd2[WD2_RANGE];
    assign cif.hold_off   = restart_run && wd_state == wd_pulse;
    assign cif.force_off  = soft_rst;
    assign cif.tick       = tick;
    assign cif.pins       = {enable_input_three, enable_input_two, enable_input_one};
    buck_channel u_chan (
      .clock  (clock),
      .resetn (resetn),
      .c      (cif.chan)
    );
    assign buck_enable[g]           = cif.conv_on;
    assign buck_voltage_code[g]     = cif.voltage_now;
    assign buck_forced_switching[g] = cif.forced_switching;
    assign ramp_st[g]               = cif.ramping;
  end

endmodule // window_watchdog_sequencer

// file: tb/wwd_asserts.sv
`timescale 1ns/100ps
module wwd_asserts #(
  parameter int BUCK_COUNT  = 2,
  parameter int TICK_CYCLES = 10
) (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic [wwd_pkg::ADDR_W-1:0] address,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic [31:0]                writedata,
  input wire logic                       waitrequest,
  input wire logic                       main_supply_input_ok,
  input wire logic                       watchdog_reset_output,
  input wire logic                       watchdog_reset_output_oe,
  input wire logic [BUCK_COUNT-1:0]      buck_enable,
  input wire logic [BUCK_COUNT-1:0][7:0] buck_voltage_code,
  input wire logic [BUCK_COUNT-1:0]      buck_forced_switching,
  input wire logic [1:0]                 general_outputs
);
  localparam int T = TICK_CYCLES;
  int run;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Tick phase lets a pulse end up to one tick early
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) run <= 0;
    else if (watchdog_reset_output == 1'b0) run <= run + 1;
    else run <= 0;
  end
  a_pulse_width: assert property (
    $rose(watchdog_reset_output) && run >= 100 && run < 1000 |-> run inside
    {[19*T:20*T+2], [21*T:22*T+2], [34*T:35*T+2], [49*T:50*T+2], [61*T:62*T+2]})
    else $error("reset pulse width wrong");
  a_oe_drive: assert property (watchdog_reset_output == 1'b0 |-> watchdog_reset_output_oe)
    else $error("reset pin low but not driven");
  a_boot_stall: assert property ($rose(resetn) && read |-> waitrequest [*3])
    else $error("request answered during boot");
  a_boot_quiet: assert property ($rose(resetn) |-> buck_enable == '0 && general_outputs == 2'h0)
    else $error("outputs active at boot");
  a_reg_enable: assert property (
    write && !waitrequest && address == 6'h00 && writedata[2:0] == 3'h1 |-> ##[1:3] buck_enable[0])
    else $error("register enable delayed");
  a_software_reset_bit: assert property (
    write && !waitrequest && address == 6'h2c && writedata[0] |-> ##[1:3] buck_enable == '0
    && general_outputs == 2'h0) else $error("software reset left outputs on");
  a_supply_off: assert property (
    !main_supply_input_ok |-> ##[1:2] buck_enable == '0 && general_outputs == 2'h0)
    else $error("supply loss left outputs on");
  a_ramp_forced: assert property (
    buck_voltage_code[0] == $past(buck_voltage_code[0]) + 8'h01 && $past(buck_enable[0])
    |-> buck_forced_switching[0])
    else $error("ramp step without forced switching");
endmodule // wwd_asserts
bind window_watchdog_sequencer wwd_asserts #(.BUCK_COUNT(BUCK_COUNT), .TICK_CYCLES(TICK_CYCLES)) chk (
  .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
  .waitrequest(waitrequest), .main_supply_input_ok(main_supply_input_ok),
  .watchdog_reset_output(watchdog_reset_output), .watchdog_reset_output_oe(watchdog_reset_output_oe),
  .buck_enable(buck_enable), .buck_voltage_code(buck_voltage_code),
  .buck_forced_switching(buck_forced_switching), .general_outputs(general_outputs));

// file: tb/host_kicker.sv
`timescale 1ns/100ps
module host_kicker #(
  parameter int HOLD = 5
) (
  input  wire logic clock,
  input  wire logic fire,
  output logic      kick
);
  int left = 0;
  // Held past the minimum width so no kick is lost
  always @(posedge clock) begin
    if (fire) left <= HOLD;
    else if (left > 0) left <= left - 1;
  end
  assign kick = left > 0;
endmodule // host_kicker

// file: tb/tb_window_watchdog_sequencer.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; $display("CHECK FAILED %0t mismatch", $time); end end
module tb_window_watchdog_sequencer;
  import wwd_pkg::*;
  typedef struct packed {logic [5:0] a; logic [31:0] v;} row_t;
  localparam int T = 10;
  logic            clock = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, fire = 1'b0;
  logic            main_supply_input_ok = 1'b1, enable_input_one = 1'b0;
  logic [5:0]      address = 6'h00;
  logic [31:0]     writedata = 32'h0, readdata, q;
  logic            waitrequest, kick, wd_out, wd_oe, wd_pin, on;
  logic [1:0]      buck_enable, forced, gpo;
  logic [1:0][7:0] code;
  int              n_fail = 0, num_checks = 0, cycles = 0, n, t;
  row_t            rows [6];
  host_kicker #(.HOLD(5)) host (.clock(clock), .fire(fire), .kick(kick));
  window_watchdog_sequencer #(.TICK_CYCLES(T), .KICK_CYCLES(3), .BOOT_CYCLES(4)) dut (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .main_supply_input_ok(main_supply_input_ok), .enable_input_one(enable_input_one),
    .enable_input_two(1'b0), .enable_input_three(1'b0), .watchdog_kick_input(kick),
    .watchdog_reset_output_in(wd_pin), .watchdog_reset_output(wd_out), .watchdog_reset_output_oe(wd_oe),
    .buck_enable(buck_enable), .buck_voltage_code(code), .buck_forced_switching(forced),
    .general_outputs(gpo));
  // Pull-up stands in for the released open-drain pin
  assign wd_pin = wd_oe ? wd_out : 1'b1;
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  function automatic logic fits(input int len, input int k);
    return len >= (k - 1) * T && len <= k * T + 2;
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Extra edge after release keeps two requests from sharing a time step
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic kick_once();
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (5) @(posedge clock);
  endtask
  task automatic pulse();
    n = 0;
    on = 1'b1;
    for (t = 0; t < 6000 && wd_out !== 1'b0; t++) @(posedge clock);
    while (wd_out === 1'b0 && n < 1000) begin
      on = on & buck_enable[0];
      @(posedge clock);
      n++;
    end
  endtask
  initial begin
    rows = '{'{WD_CTRL1_ADDR, 32'(WD1_DEFAULT)}, '{WD_CTRL2_ADDR, 32'(WD2_DEFAULT)}, '{6'h08, 32'(VOUT_DEFAULT)},
             '{6'h18, 32'(VOUT_DEFAULT)}, '{6'h00, 32'(CTRL1_DEFAULT)}, '{6'h3c, 32'h0}};
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b0, 32'h0);
      `CHK(q, rows[i].v)
    end
    bus(6'h00, 1'b1, 32'h01);
    bus(RESET_ADDR, 1'b1, 32'h06);
    repeat (2) @(posedge clock);
    `CHK(buck_enable[0], 1'b1)
    `CHK(gpo, 2'h3)
    bus(6'h08, 1'b1, 32'h34);
    repeat (3) @(posedge clock);
    `CHK(forced[0], 1'b1)
    for (t = 0; t < 200 && code[0] !== 8'h34; t++) @(posedge clock);
    repeat (3) @(posedge clock);
    `CHK(code[0], 8'h34)
    `CHK(forced[0], 1'b0)
    pulse();
    `CHK(fits(n, int'(REGONLY_T)), 1'b1)
    `CHK(on, 1'b1)
    bus(WD_CTRL2_ADDR, 1'b1, 32'h07);
    bus(WD_CTRL2_ADDR, 1'b1, 32'h00);
    bus(WD_CTRL2_ADDR, 1'b0, 32'h0);
    `CHK(q, 32'h07)
    kick_once();
    kick_once();
    pulse();
    `CHK(fits(n, int'(PULSE_T)), 1'b1)
    bus(WD_STAT_ADDR, 1'b0, 32'h0);
    `CHK(q, 32'h02)
    bus(WD_STAT_ADDR, 1'b1, 32'h02);
    bus(WD_STAT_ADDR, 1'b0, 32'h0);
    `CHK(q, 32'h00)
    bus(RESET_ADDR, 1'b1, 32'h01);
    repeat (2) @(posedge clock);
    `CHK(buck_enable, 2'h0)
    `CHK(gpo, 2'h0)
    repeat (6) @(posedge clock);
    bus(WD_CTRL2_ADDR, 1'b0, 32'h0);
    `CHK(q, 32'(WD2_DEFAULT))
    bus(6'h00, 1'b1, 32'h01);
    main_supply_input_ok <= 1'b0;
    repeat (3) @(posedge clock);
    main_supply_input_ok <= 1'b1;
    `CHK(buck_enable, 2'h0)
    repeat (6) @(posedge clock);
    bus(6'h00, 1'b0, 32'h0);
    `CHK(q, 32'(CTRL1_DEFAULT))
    bus(6'h0c, 1'b1, 32'h23);
    bus(6'h00, 1'b1, 32'h03);
    enable_input_one <= 1'b1;
    repeat (2 * T + 1) @(posedge clock);
    `CHK(buck_enable[0], 1'b0)
    repeat (T + 2) @(posedge clock);
    `CHK(buck_enable[0], 1'b1)
    kick_once();
    kick_once();
    pulse();
    `CHK(fits(n, int'(PULSE_T + SHUT_S_T)), 1'b1)
    `CHK(on, 1'b0)
    bus(WD_STAT_ADDR, 1'b0, 32'h0);
    `CHK(q, 32'h01)
    repeat (3 * T) @(posedge clock);
    `CHK(buck_enable[0], 1'b1)
    conclude();
  end
endmodule // tb_window_watchdog_sequencer
